/* File: design/sbtc_pkg.sv */
`default_nettype none
package sbtc_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h11;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h12;
  localparam logic [7:0] ADDR_IRQ = 8'h13;
  localparam int BIT_ON = 0;
  localparam int BIT_CLKSEL = 1;
  localparam int BIT_SYNC_DIS = 2;
  localparam int BIT_OSC_EN = 3;
  localparam int BIT_PS_LO = 4;
  localparam int BIT_PS_HI = 5;
  localparam int BIT_RUN = 6;
  localparam int BIT_FLAG = 0;
  localparam int BIT_IRQ_EN = 1;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'h3F;
  localparam logic [1:0] SYSCLK_FROM_OSC = 2'h1;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam int PS_WIDTH = 3;
endpackage
`default_nettype wire

/* File: design/sbtc_edge_if.sv */
`default_nettype none
interface sbtc_edge_if;
  logic raw;
  logic rise;
  logic fall;
  modport src (input raw, output rise, output fall);
  modport dst (output raw, input rise, input fall);
endinterface
`default_nettype wire

/* File: design/sbtc_pin_sync.sv */
`default_nettype none
// three-stage pin synchroniser with edge detection
module sbtc_pin_sync
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  sbtc_edge_if.src edge_if
);
  logic [2:0] stage;
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      stage <= 3'h0;
    else
      stage <= {stage[1:0], edge_if.raw};
  end
  // stage 0 feeds stage 1 only
  assign edge_if.rise = stage[1] & ~stage[2];
  assign edge_if.fall = ~stage[1] & stage[2];
endmodule // sbtc_pin_sync
`default_nettype wire

/* File: design/sbtc_timer.sv */
`default_nettype none
module sbtc_timer
#(
  parameter int QUARTERS = 4
)
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic power_reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [7:0] rdata_o,
  input wire logic external_clock_pin_i,
  input wire logic osc_input_pin_i,
  input wire logic [1:0] system_clock_select_i,
  input wire logic sleep_i,
  input wire logic special_event_i,
  input wire logic [1:0] port_direction_reg_i,
  input wire logic [1:0] port_out_i,
  output logic [1:0] port_oe_o,
  output logic [1:0] port_out_o,
  output logic [1:0] port_in_gate_o,
  output logic osc_inverter_on_o,
  output logic irq_o,
  output logic wake_o
);
  logic [7:0] control;
  logic [15:0] count;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic [1:0] quarter;
  logic armed;
  logic [sbtc_pkg::PS_WIDTH-1:0] prescale;
  logic ps_out_q;
  logic [7:0] next_rdata;
  sbtc_edge_if pin_if ();

  wire counter_on = control[sbtc_pkg::BIT_ON];
  wire clock_source_select = control[sbtc_pkg::BIT_CLKSEL];
  wire sync_disable = control[sbtc_pkg::BIT_SYNC_DIS];
  wire osc_enable = control[sbtc_pkg::BIT_OSC_EN];
  wire [1:0] input_prescale = control[sbtc_pkg::BIT_PS_HI:sbtc_pkg::BIT_PS_LO];
  wire osc_sysclk_status = (system_clock_select_i == sbtc_pkg::SYSCLK_FROM_OSC);

  assign pin_if.raw = osc_enable ? osc_input_pin_i : external_clock_pin_i;

  sbtc_pin_sync u_pin_sync
  (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .edge_if(pin_if)
  );

  wire wr_ctrl = write_i && (addr_i == sbtc_pkg::ADDR_CONTROL);
  wire wr_low = write_i && (addr_i == sbtc_pkg::ADDR_COUNT_LOW);
  wire wr_high = write_i && (addr_i == sbtc_pkg::ADDR_COUNT_HIGH);
  wire wr_irq = write_i && (addr_i == sbtc_pkg::ADDR_IRQ);
  wire wr_count = wr_low || wr_high;

  // prescaler counts external rising edges, also in sleep
  wire ext_rise = clock_source_select && armed && pin_if.rise;
  wire [sbtc_pkg::PS_WIDTH-1:0] ps_next = prescale + {{(sbtc_pkg::PS_WIDTH-1){1'b0}}, 1'b1};
  wire ps_tap = (input_prescale == 2'h0) ? 1'b0 : prescale[input_prescale - 2'h1];

  // divided external clock, one edge per N input rises
  wire ext_tick_unsynced = (input_prescale == 2'h0) ? ext_rise : (ps_tap & ~ps_out_q);
  wire ext_tick = (sync_disable || !sleep_i) ? ext_tick_unsynced : 1'b0;

  wire internal_tick = !sleep_i && (quarter == sbtc_pkg::Q_LAST);
  wire tick = counter_on && (clock_source_select ? ext_tick : internal_tick);
  wire wrap = tick && (count == 16'hFFFF);

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      quarter <= 2'h0;
    else
      quarter <= quarter + 2'h1;
  end

  // arm after first falling edge once counter mode enabled
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      armed <= 1'b0;
    else if (!counter_on || !clock_source_select)
      armed <= 1'b0;
    else if (pin_if.fall)
      armed <= 1'b1;
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prescale <= '0;
      ps_out_q <= 1'b0;
    end
    else if (wr_count)
    begin
      prescale <= '0;
      ps_out_q <= 1'b0;
    end
    else
    begin
      if (ext_rise)
        prescale <= ps_next;
      ps_out_q <= ps_tap;
    end
  end

  // power-on/brown-out reset alone clears control
  always_ff @(posedge clock_i or negedge power_reset_n_i)
  begin
    if (!power_reset_n_i)
      control <= sbtc_pkg::CONTROL_RESET;
    else if (wr_ctrl)
      control <= wdata_i & sbtc_pkg::CONTROL_WMASK;
  end

  // count bytes are not touched by any system reset
  always_ff @(posedge clock_i)
  begin
    if (wr_low)
      count[7:0] <= wdata_i;
    else if (special_event_i)
      count[7:0] <= 8'h00;
    else if (tick)
      count[7:0] <= count[7:0] + 8'h01;
    if (wr_high)
      count[15:8] <= wdata_i;
    else if (special_event_i)
      count[15:8] <= 8'h00;
    else if (tick && count[7:0] == 8'hFF)
      count[15:8] <= count[15:8] + 8'h01;
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      overflow_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end
    else
    begin
      if (wrap)
        overflow_flag <= 1'b1;
      else if (wr_irq)
        overflow_flag <= wdata_i[sbtc_pkg::BIT_FLAG];
      if (wr_irq)
        overflow_irq_enable <= wdata_i[sbtc_pkg::BIT_IRQ_EN];
    end
  end

  assign irq_o = overflow_flag && overflow_irq_enable;
  assign wake_o = irq_o && sleep_i;

  always_comb
  begin
    next_rdata = 8'h00;
    case (addr_i)
      sbtc_pkg::ADDR_CONTROL: next_rdata = {1'b0, osc_sysclk_status, control[5:0]};
      sbtc_pkg::ADDR_COUNT_LOW: next_rdata = count[7:0];
      sbtc_pkg::ADDR_COUNT_HIGH: next_rdata = count[15:8];
      sbtc_pkg::ADDR_IRQ: next_rdata = {6'h00, overflow_irq_enable, overflow_flag};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_o <= 8'h00;
    else if (read_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= 8'h00;
  end

  // oscillator pins become inputs and read as zero
  assign osc_inverter_on_o = osc_enable;
  assign port_oe_o = osc_enable ? 2'h0 : ~port_direction_reg_i;
  assign port_out_o = port_out_i;
  assign port_in_gate_o = osc_enable ? 2'h0 : 2'h3;
endmodule // sbtc_timer
`default_nettype wire

/* File: verification/sbtc_timer_props.sv */
`default_nettype none
module sbtc_timer_props
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire logic [7:0] rdata_o,
  input wire logic [1:0] system_clock_select_i,
  input wire logic sleep_i,
  input wire logic [1:0] port_oe_o,
  input wire logic [1:0] port_in_gate_o,
  input wire logic osc_inverter_on_o,
  input wire logic irq_o,
  input wire logic wake_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  wire logic irq_wr = write_i && addr_i == sbtc_pkg::ADDR_IRQ;
  wire logic ctl_wr = write_i && addr_i == sbtc_pkg::ADDR_CONTROL;
  wire logic ctl_rd = read_i && addr_i == sbtc_pkg::ADDR_CONTROL;
  pin_lock_a: assert property (osc_inverter_on_o |-> port_oe_o == 2'h0 && port_in_gate_o == 2'h0)
    else $error("pins not released");
  pin_open_a: assert property (!osc_inverter_on_o |-> port_in_gate_o == 2'h3)
    else $error("pin read gated");
  wake_gate_a: assert property (wake_o == (irq_o && sleep_i)) else $error("wake wrong");
  top_bit_a: assert property ($past(read_i) |-> !rdata_o[7]) else $error("bit 7 set");
  osc_status_a: assert property (ctl_rd |=> rdata_o[6] ==
    ($past(system_clock_select_i) == sbtc_pkg::SYSCLK_FROM_OSC)) else $error("status wrong");
  osc_follow_a: assert property (ctl_wr |=> osc_inverter_on_o == $past(wdata_i[3]))
    else $error("osc enable wrong");
  irq_mask_a: assert property (irq_wr && !wdata_i[1] |=> !irq_o) else $error("irq not masked");
  irq_raise_a: assert property (irq_wr && wdata_i[1:0] == 2'h3 |=> irq_o) else $error("irq missing");
  cover property (wake_o);
  cover property (irq_o ##1 !irq_o);
  cover property (ctl_rd ##1 rdata_o[6]);
endmodule // sbtc_timer_props
bind sbtc_timer sbtc_timer_props u_props (.clock_i, .reset_n_i, .addr_i, .wdata_i, .write_i, .read_i,
  .rdata_o, .system_clock_select_i, .sleep_i, .port_oe_o, .port_in_gate_o, .osc_inverter_on_o, .irq_o, .wake_o);
`default_nettype wire

/* File: verification/tb_sbtc_timer.sv */
`default_nettype none
module tb_sbtc_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'h0, reset_n_i = 1'h0, write_i = 1'h0, read_i = 1'h0, sev = 1'h0, slp = 1'h0;
  logic osc = 1'h0, wave = 1'h0, rd_d = 1'h0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, q[$];
  logic [1:0] sel = 2'h0;
  logic [3:0] r;
  logic [15:0] v = 16'h0000;
  int error_cnt = 0, compares = 0;
  sbtc_timer dut (.clock_i, .reset_n_i, .power_reset_n_i(reset_n_i), .addr_i, .wdata_i, .write_i, .read_i,
    .rdata_o, .external_clock_pin_i(osc | wave), .osc_input_pin_i(!osc | wave), .system_clock_select_i(sel),
    .sleep_i(slp), .special_event_i(sev), .port_direction_reg_i(v[1:0]), .port_out_i(v[3:2]), .port_oe_o(),
    .port_out_o(), .port_in_gate_o(), .osc_inverter_on_o(), .irq_o(), .wake_o());
  task automatic bus(input logic w, input logic [7:0] a, d);
    if (!w)
      q.push_back(d);
    {write_i, read_i} <= {w, !w};
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
  endtask
  task automatic idle(input int n);
    {write_i, read_i} <= 2'h0;
    repeat (n) @(posedge clock_i);
  endtask
  task automatic chk(input logic [7:0] e, s);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("FAIL rdata expected %h seen %h", e, s);
    end
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock_i)
  begin
    if (rd_d)
      chk(q.pop_front(), rdata_o);
    rd_d <= read_i;
  end
  initial
  begin
    forever #20 clock_i = ~clock_i;
  end
  initial
  begin
    repeat (5000) @(posedge clock_i);
    error_cnt++;
    test_done;
  end
  initial
  begin
    void'($urandom(76573));
    repeat (10) @(posedge clock_i);
    reset_n_i <= 1'h1;
    v <= 16'($urandom);
    sel <= sbtc_pkg::SYSCLK_FROM_OSC;
    @(posedge clock_i);
    bus(0, sbtc_pkg::ADDR_CONTROL, 8'h40);
    bus(1, sbtc_pkg::ADDR_CONTROL, 8'hFE);
    bus(0, sbtc_pkg::ADDR_CONTROL, 8'h7E);
    sel <= 2'h2;
    bus(0, sbtc_pkg::ADDR_CONTROL, 8'h3E);
    bus(1, sbtc_pkg::ADDR_COUNT_LOW, v[7:0]);
    bus(1, sbtc_pkg::ADDR_COUNT_HIGH, v[15:8]);
    bus(0, sbtc_pkg::ADDR_COUNT_LOW, v[7:0]);
    bus(0, sbtc_pkg::ADDR_COUNT_HIGH, v[15:8]);
    bus(1, sbtc_pkg::ADDR_IRQ, 8'h02);
    sev <= 1'h1;
    bus(1, sbtc_pkg::ADDR_COUNT_LOW, 8'h5A);
    sev <= 1'h0;
    bus(0, sbtc_pkg::ADDR_COUNT_LOW, 8'h5A);
    bus(0, sbtc_pkg::ADDR_COUNT_HIGH, 8'h00);
    bus(0, sbtc_pkg::ADDR_IRQ, 8'h02);
    bus(1, sbtc_pkg::ADDR_COUNT_LOW, 8'hFF);
    bus(1, sbtc_pkg::ADDR_COUNT_HIGH, 8'hFF);
    bus(1, sbtc_pkg::ADDR_CONTROL, 8'h01);
    idle(20);
    bus(1, sbtc_pkg::ADDR_CONTROL, 8'h00);
    bus(0, sbtc_pkg::ADDR_COUNT_HIGH, 8'h00);
    bus(0, sbtc_pkg::ADDR_IRQ, 8'h03);
    bus(1, sbtc_pkg::ADDR_IRQ, 8'h03);
    slp <= 1'h1;
    idle(2);
    slp <= 1'h0;
    bus(1, sbtc_pkg::ADDR_IRQ, 8'h00);
    bus(0, sbtc_pkg::ADDR_IRQ, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      r = 4'($urandom);
      osc <= r[0];
      wave <= k != 0;
      idle(6);
      bus(1, sbtc_pkg::ADDR_COUNT_LOW, 8'h00);
      bus(1, sbtc_pkg::ADDR_COUNT_HIGH, 8'h00);
      bus(1, sbtc_pkg::ADDR_CONTROL, {2'h0, 2'(k), r[0], r[1], 2'h3});
      repeat (16)
      begin
        wave <= 1'h0;
        idle(4);
        wave <= 1'h1;
        idle(4);
      end
      idle(8);
      bus(1, sbtc_pkg::ADDR_CONTROL, 8'h00);
      bus(0, sbtc_pkg::ADDR_COUNT_LOW, k == 0 ? 8'h0F : 8'h10 >> k);
    end
    idle(2);
    test_done;
  end
endmodule // tb_sbtc_timer
`default_nettype wire
